// >>> src/angx_regs.svh
// Register offsets, field positions, reset values for the partner
// and next-page register bank. Included by the bank and the bench.
`ifndef ANGX_REGS_SVH
`define ANGX_REGS_SVH
`define ANGX_OFF_PARTNER 12'h014
`define ANGX_OFF_EXPAN 12'h018
`define ANGX_OFF_NPTX 12'h01c
`define ANGX_OFF_NPRX 12'h020
`define ANGX_OFF_GIGCTL 12'h024
`define ANGX_IDX_PARTNER 5
`define ANGX_IDX_EXPAN 6
`define ANGX_IDX_NPTX 7
`define ANGX_IDX_NPRX 8
`define ANGX_IDX_GIGCTL 9
`define ANGX_BIT_NP 15
`define ANGX_BIT_ACK 14
`define ANGX_BIT_RF 13
`define ANGX_BIT_MSG 13
`define ANGX_BIT_ACK2 12
`define ANGX_BIT_TOGGLE 11
`define ANGX_BIT_APAUSE 11
`define ANGX_BIT_SPAUSE 10
`define ANGX_BIT_PDF 4
`define ANGX_BIT_LPNP 3
`define ANGX_BIT_LOCNP 2
`define ANGX_BIT_PGRX 1
`define ANGX_BIT_LPAN 0
`define ANGX_BIT_MSMAN 12
`define ANGX_BIT_MSVAL 11
`define ANGX_BIT_PTYPE 10
`define ANGX_BIT_GFDX 9
`define ANGX_BIT_GHDX 8
`define ANGX_RST_NPCODE 11'h001
`define ANGX_RST_MSG 1'b1
`define ANGX_RST_PTYPE 1'b1
`define ANGX_RST_GFDX 1'b1
`define ANGX_RST_GHDX 1'b1
`define ANGX_RST_LOCNP 1'b1
`define ANGX_RST_TMODE 3'h0
`endif

// >>> src/angx_pkg.sv
// Types for the partner and next-page register bank.
// Assumes angx_regs.svh alongside for numeric constants.
package angx_pkg;
	typedef enum logic [2:0] {
		ANGX_TM_NORMAL = 3'h0,
		ANGX_TM_WAVE = 3'h1,
		ANGX_TM_JIT_M = 3'h2,
		ANGX_TM_JIT_S = 3'h3,
		ANGX_TM_DIST = 3'h4
	} angx_tmode_t;
	typedef enum logic [1:0] {
		ANGX_ST_IDLE = 2'b01,
		ANGX_ST_ACCESS = 2'b10
	} angx_apb_st_t;
	typedef struct packed {
		angx_apb_st_t st;
		logic [2:0] tmode;
		logic ms_man;
		logic ms_val;
		logic ptype;
		logic gfdx;
		logic ghdx;
		logic np_more;
		logic np_msg;
		logic np_ack2;
		logic [10:0] np_code;
		logic pdf_latch;
		logic pgrx_latch;
		logic [31:0] prdata;
	} angx_state_t;
endpackage

// >>> src/angx_bank.sv
// APB register bank: partner ability, expansion, next-page tx/rx,
// gigabit control. Assumes a negotiation engine drives the partner
// inputs synchronously to CLOCK_I and reads the control outputs.
//
// Operation
// [RULE1] Partner NP, ack, remote fault read-only
// [RULE2] Partner pause abilities read-only
// [RULE3] Partner speed abilities and selector field
// [RULE4] Parallel detection fault latches until read
// [RULE5] Partner next-page ability shown
// [RULE6] Local next-page capable reads one
// [RULE7] Page received latch, cleared by read
// [RULE8] Partner autonegotiation ability shown
// [RULE9] Next-page tx writable fields with resets
// [RULE10] Software sets ack2 compliance bit
// [RULE11] Toggle is inverse of previous codeword
// [RULE12] Received partner next page read-only
// [RULE13] Test mode field selects transmitter test
// [RULE14] Manual master/slave enable bit
// [RULE15] Master/slave value only when manual
// [RULE16] Port type advertisement, reset one
// [RULE17] Gigabit duplex advertisement, reset one
// [RULE18] Software disables media sense before tests
// [RULE19] Software sets master/slave before forcing gigabit
// [RULE20] Read-only and reserved writes ignored
//
// Register access over APB was chosen for this implementation.
`include "angx_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module angx_bank
	import angx_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic [31:0] PRDATA_O,
	input wire logic [15:0] PARTNER_BASE_I,
	input wire logic [15:0] PARTNER_NP_I,
	input wire logic PARTNER_NP_ABLE_I,
	input wire logic PARTNER_AN_ABLE_I,
	input wire logic PAR_DET_FAULT_I,
	input wire logic PAGE_RX_I,
	input wire logic LAST_CODEWORD_TOGGLE_I,
	output logic [2:0] TEST_MODE_O,
	output logic MS_MANUAL_O,
	output logic MS_FORCE_MASTER_O,
	output logic PORT_MULTI_O,
	output logic GIG_FDX_ADV_O,
	output logic GIG_HDX_ADV_O,
	output logic [15:0] NP_TX_WORD_O
);
	angx_state_t s_reg;
	angx_state_t s_next;
	logic setup;
	logic access;
	logic [9:0] idx;
	logic mapped;
	logic lo_wr;
	logic hi_wr;
	logic [15:0] partner_word;
	logic [15:0] expan_word;
	logic [15:0] nptx_word;
	logic [15:0] nprx_word;
	logic [15:0] gig_word;

	assign setup = PSEL_I && !PENABLE_I;
	assign access = PSEL_I && PENABLE_I;
	assign idx = PADDR_I[11:2];
	assign mapped = (idx >= 10'(`ANGX_IDX_PARTNER))
		&& (idx <= 10'(`ANGX_IDX_GIGCTL));
	assign lo_wr = PSTRB_I[0];
	assign hi_wr = PSTRB_I[1];

	// Partner fields pass straight from the engine, current state
	assign partner_word = PARTNER_BASE_I; // [RULE1] [RULE2] [RULE3]
	always_comb begin
		expan_word = 16'h0000;
		expan_word[`ANGX_BIT_PDF] = s_reg.pdf_latch; // [RULE4]
		expan_word[`ANGX_BIT_LPNP] = PARTNER_NP_ABLE_I; // [RULE5]
		expan_word[`ANGX_BIT_LOCNP] = `ANGX_RST_LOCNP; // [RULE6]
		expan_word[`ANGX_BIT_PGRX] = s_reg.pgrx_latch; // [RULE7]
		expan_word[`ANGX_BIT_LPAN] = PARTNER_AN_ABLE_I; // [RULE8]
	end
	always_comb begin
		nptx_word = 16'h0000;
		nptx_word[`ANGX_BIT_NP] = s_reg.np_more; // [RULE9]
		nptx_word[`ANGX_BIT_MSG] = s_reg.np_msg;
		nptx_word[`ANGX_BIT_ACK2] = s_reg.np_ack2; // [RULE10]
		nptx_word[`ANGX_BIT_TOGGLE] = !LAST_CODEWORD_TOGGLE_I; // [RULE11]
		nptx_word[10:0] = s_reg.np_code;
	end
	assign nprx_word = PARTNER_NP_I; // [RULE12]
	always_comb begin
		gig_word = 16'h0000; // Reserved low byte reads zero
		gig_word[15:13] = s_reg.tmode;
		gig_word[`ANGX_BIT_MSMAN] = s_reg.ms_man;
		gig_word[`ANGX_BIT_MSVAL] = s_reg.ms_val;
		gig_word[`ANGX_BIT_PTYPE] = s_reg.ptype;
		gig_word[`ANGX_BIT_GFDX] = s_reg.gfdx;
		gig_word[`ANGX_BIT_GHDX] = s_reg.ghdx;
	end

	always_comb begin
		s_next = s_reg;
		// Set beats the read-clear so no event is lost
		case (s_reg.st)
		ANGX_ST_IDLE: begin
			if (setup) begin
				s_next.st = ANGX_ST_ACCESS;
				// Word captured at setup so it stands with PREADY
				if (!PWRITE_I) begin
					case (idx)
					10'(`ANGX_IDX_PARTNER): begin
						s_next.prdata = {16'h0000, partner_word};
					end
					10'(`ANGX_IDX_EXPAN): begin
						s_next.prdata = {16'h0000, expan_word};
					end
					10'(`ANGX_IDX_NPTX): begin
						s_next.prdata = {16'h0000, nptx_word};
					end
					10'(`ANGX_IDX_NPRX): begin
						s_next.prdata = {16'h0000, nprx_word};
					end
					10'(`ANGX_IDX_GIGCTL): begin
						s_next.prdata = {16'h0000, gig_word};
					end
					default: s_next.prdata = 32'h0000_0000;
					endcase
				end
			end
		end
		ANGX_ST_ACCESS: begin
			s_next.st = ANGX_ST_IDLE;
			if (access && !PWRITE_I) begin
				// Only a reported event is cleared; a newer one survives
				if (idx == 10'(`ANGX_IDX_EXPAN)) begin
					s_next.pdf_latch = s_reg.pdf_latch
						&& !s_reg.prdata[`ANGX_BIT_PDF]; // [RULE4]
					s_next.pgrx_latch = s_reg.pgrx_latch
						&& !s_reg.prdata[`ANGX_BIT_PGRX]; // [RULE7]
				end
			end else if (access && idx == 10'(`ANGX_IDX_NPTX)) begin
				// Toggle bit 11 and bit 14 are not writable
				if (hi_wr) begin // [RULE20]
					s_next.np_more = PWDATA_I[`ANGX_BIT_NP]; // [RULE9]
					s_next.np_msg = PWDATA_I[`ANGX_BIT_MSG];
					s_next.np_ack2 = PWDATA_I[`ANGX_BIT_ACK2]; // [RULE10]
					s_next.np_code[10:8] = PWDATA_I[10:8];
				end
				if (lo_wr) begin
					s_next.np_code[7:0] = PWDATA_I[7:0];
				end
			end else if (access && idx == 10'(`ANGX_IDX_GIGCTL)) begin
				if (hi_wr) begin
					s_next.tmode = PWDATA_I[15:13]; // [RULE13]
					s_next.ms_man = PWDATA_I[`ANGX_BIT_MSMAN]; // [RULE14]
					s_next.ms_val = PWDATA_I[`ANGX_BIT_MSVAL];
					s_next.ptype = PWDATA_I[`ANGX_BIT_PTYPE]; // [RULE16]
					s_next.gfdx = PWDATA_I[`ANGX_BIT_GFDX]; // [RULE17]
					s_next.ghdx = PWDATA_I[`ANGX_BIT_GHDX];
				end
			end
		end
		default: s_next.st = ANGX_ST_IDLE;
		endcase
		if (PAR_DET_FAULT_I) begin
			s_next.pdf_latch = 1'b1; // [RULE4]
		end
		if (PAGE_RX_I) begin
			s_next.pgrx_latch = 1'b1; // [RULE7]
		end
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s_reg.st <= ANGX_ST_IDLE;
			s_reg.tmode <= `ANGX_RST_TMODE;
			s_reg.ms_man <= 1'b0;
			s_reg.ms_val <= 1'b0;
			s_reg.ptype <= `ANGX_RST_PTYPE;
			s_reg.gfdx <= `ANGX_RST_GFDX;
			s_reg.ghdx <= `ANGX_RST_GHDX;
			s_reg.np_more <= 1'b0;
			s_reg.np_msg <= `ANGX_RST_MSG;
			s_reg.np_ack2 <= 1'b0;
			s_reg.np_code <= `ANGX_RST_NPCODE;
			s_reg.pdf_latch <= 1'b0;
			s_reg.pgrx_latch <= 1'b0;
			s_reg.prdata <= 32'h0000_0000;
		end else begin
			s_reg <= s_next;
		end
	end

	// No wait state: answer in the first access cycle after the setup
	assign PREADY_O = access && (s_reg.st == ANGX_ST_ACCESS);
	assign PSLVERR_O = PREADY_O && !mapped;
	assign PRDATA_O = s_reg.prdata;
	assign TEST_MODE_O = s_reg.tmode; // [RULE13]
	assign MS_MANUAL_O = s_reg.ms_man; // [RULE14]
	// Value bit ignored while automatic resolution runs
	assign MS_FORCE_MASTER_O = s_reg.ms_man && s_reg.ms_val; // [RULE15]
	assign PORT_MULTI_O = s_reg.ptype;
	assign GIG_FDX_ADV_O = s_reg.gfdx;
	assign GIG_HDX_ADV_O = s_reg.ghdx;
	assign NP_TX_WORD_O = nptx_word;

	property p_pdf_hold;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_reg.pdf_latch && !(PREADY_O && !PWRITE_I
			&& idx == 10'(`ANGX_IDX_EXPAN)) |=> s_reg.pdf_latch;
	endproperty
	a_pdf_hold: assert property (p_pdf_hold) // [RULE4]
		else $error("fault latch dropped without read");
	property p_pdf_set;
		@(posedge CLOCK_I) disable iff (RESET_I)
		PAR_DET_FAULT_I |=> expan_word[`ANGX_BIT_PDF];
	endproperty
	a_pdf_set: assert property (p_pdf_set) // [RULE4]
		else $error("fault event lost");
	property p_pgrx_set;
		@(posedge CLOCK_I) disable iff (RESET_I)
		PAGE_RX_I |=> expan_word[`ANGX_BIT_PGRX];
	endproperty
	a_pgrx_set: assert property (p_pgrx_set) // [RULE7]
		else $error("page event lost");
	property p_locnp;
		@(posedge CLOCK_I) disable iff (RESET_I)
		expan_word[`ANGX_BIT_LOCNP] && expan_word[15:5] == 11'h000;
	endproperty
	a_locnp: assert property (p_locnp) // [RULE6]
		else $error("expansion constant bits wrong");
	property p_toggle;
		@(posedge CLOCK_I) disable iff (RESET_I)
		NP_TX_WORD_O[`ANGX_BIT_TOGGLE] != LAST_CODEWORD_TOGGLE_I;
	endproperty
	a_toggle: assert property (p_toggle) // [RULE11]
		else $error("toggle not inverted");
	property p_msval;
		@(posedge CLOCK_I) disable iff (RESET_I)
		!MS_MANUAL_O |-> !MS_FORCE_MASTER_O;
	endproperty
	a_msval: assert property (p_msval) // [RULE15]
		else $error("master forced without manual mode");
	sequence s_gig_write;
		PREADY_O && PWRITE_I && PSTRB_I[1]
			&& idx == 10'(`ANGX_IDX_GIGCTL);
	endsequence
	property p_tmode_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_gig_write |=> TEST_MODE_O == $past(PWDATA_I[15:13]);
	endproperty
	a_tmode_wr: assert property (p_tmode_wr) // [RULE13]
		else $error("test mode not written");
	property p_nptx_ro;
		@(posedge CLOCK_I) disable iff (RESET_I)
		NP_TX_WORD_O[14] == 1'b0;
	endproperty
	a_nptx_ro: assert property (p_nptx_ro) // [RULE20]
		else $error("reserved bit set");
	property p_nprx;
		@(posedge CLOCK_I) disable iff (RESET_I)
		PREADY_O && !PWRITE_I && idx == 10'(`ANGX_IDX_NPRX)
			|-> PRDATA_O[15:0] == $past(PARTNER_NP_I);
	endproperty
	a_nprx: assert property (p_nprx) // [RULE12]
		else $error("received page readback wrong");
	sequence s_expan_read;
		PREADY_O && !PWRITE_I && idx == 10'(`ANGX_IDX_EXPAN);
	endsequence
	sequence s_np_write;
		PREADY_O && PWRITE_I && PSTRB_I[1:0] == 2'b11
			&& idx == 10'(`ANGX_IDX_NPTX);
	endsequence
	sequence s_ro_write;
		PREADY_O && PWRITE_I && (idx == 10'(`ANGX_IDX_PARTNER)
			|| idx == 10'(`ANGX_IDX_EXPAN)
			|| idx == 10'(`ANGX_IDX_NPRX) || !mapped);
	endsequence
	property p_pgrx_hold;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_reg.pgrx_latch && !(PREADY_O && !PWRITE_I
			&& idx == 10'(`ANGX_IDX_EXPAN)) |=> s_reg.pgrx_latch;
	endproperty
	a_pgrx_hold: assert property (p_pgrx_hold) // [RULE7]
		else $error("page latch dropped without read");
	property p_rd_partner;
		@(posedge CLOCK_I) disable iff (RESET_I)
		PREADY_O && !PWRITE_I && idx == 10'(`ANGX_IDX_PARTNER)
			|-> PRDATA_O[15:0] == $past(PARTNER_BASE_I);
	endproperty
	a_rd_partner: assert property (p_rd_partner) // [RULE1]
		else $error("partner ability readback wrong");
	property p_rd_lpnp;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_expan_read |-> PRDATA_O[`ANGX_BIT_LPNP]
			== $past(PARTNER_NP_ABLE_I);
	endproperty
	a_rd_lpnp: assert property (p_rd_lpnp) // [RULE5]
		else $error("partner next-page ability wrong");
	property p_rd_lpan;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_expan_read |-> PRDATA_O[`ANGX_BIT_LPAN]
			== $past(PARTNER_AN_ABLE_I);
	endproperty
	a_rd_lpan: assert property (p_rd_lpan) // [RULE8]
		else $error("partner negotiation ability wrong");
	property p_rd_const;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_expan_read |-> PRDATA_O[`ANGX_BIT_LOCNP]
			&& PRDATA_O[31:5] == 27'h0000000;
	endproperty
	a_rd_const: assert property (p_rd_const) // [RULE6]
		else $error("expansion readback constant bits wrong");
	property p_np_more_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_np_write |=> NP_TX_WORD_O[`ANGX_BIT_NP]
			== $past(PWDATA_I[`ANGX_BIT_NP]);
	endproperty
	a_np_more_wr: assert property (p_np_more_wr) // [RULE9]
		else $error("next-page flag not written");
	property p_np_code_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_np_write |=> NP_TX_WORD_O[10:0] == $past(PWDATA_I[10:0]);
	endproperty
	a_np_code_wr: assert property (p_np_code_wr) // [RULE9]
		else $error("next-page code not written");
	property p_ack2_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_np_write |=> NP_TX_WORD_O[`ANGX_BIT_ACK2]
			== $past(PWDATA_I[`ANGX_BIT_ACK2]);
	endproperty
	a_ack2_wr: assert property (p_ack2_wr) // [RULE10]
		else $error("compliance bit not written");
	property p_msman_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_gig_write |=> MS_MANUAL_O == $past(PWDATA_I[`ANGX_BIT_MSMAN]);
	endproperty
	a_msman_wr: assert property (p_msman_wr) // [RULE14]
		else $error("manual enable not written");
	property p_ptype_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_gig_write |=> PORT_MULTI_O == $past(PWDATA_I[`ANGX_BIT_PTYPE]);
	endproperty
	a_ptype_wr: assert property (p_ptype_wr) // [RULE16]
		else $error("port type not written");
	property p_gdx_wr;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_gig_write |=> {GIG_FDX_ADV_O, GIG_HDX_ADV_O}
			== $past(PWDATA_I[`ANGX_BIT_GFDX:`ANGX_BIT_GHDX]);
	endproperty
	a_gdx_wr: assert property (p_gdx_wr) // [RULE17]
		else $error("duplex advertisement not written");
	property p_ro_write;
		@(posedge CLOCK_I) disable iff (RESET_I)
		s_ro_write |=> $stable(TEST_MODE_O) && $stable(PORT_MULTI_O)
			&& $stable(NP_TX_WORD_O[10:0]);
	endproperty
	a_ro_write: assert property (p_ro_write) // [RULE20]
		else $error("read-only write changed state");
	property p_ready_pulse;
		@(posedge CLOCK_I) disable iff (RESET_I)
		PREADY_O |=> !PREADY_O;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) // [RULE20]
		else $error("ready held beyond one cycle");
endmodule
`default_nettype wire

// >>> verification/angx_partner_model.sv
// Far side model: remote partner pages, fault events, toggle.
// Assumes bench pulses send_i and fault_i just after CLOCK_I edges.
`timescale 1ns/10ps
`default_nettype none
module angx_partner_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_i,
	input wire logic fault_i,
	input wire logic [15:0] word_i,
	output logic [15:0] base_o,
	output logic [15:0] np_o,
	output logic page_o,
	output logic pdf_o,
	output logic tog_o
);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			base_o <= 16'h0000;
			np_o <= 16'h0000;
			page_o <= 1'b0;
			pdf_o <= 1'b0;
			tog_o <= 1'b0;
		end else begin
			page_o <= send_i;
			pdf_o <= fault_i;
			if (send_i) begin
				base_o <= word_i;
				np_o <= ~word_i;
				tog_o <= ~tog_o; // Every sent codeword flips it
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/angx_bank_tb.sv
// Self-checking bench for angx_bank over APB.
// Assumes angx_regs.svh on the include path; one 250 MHz clock.
`include "angx_regs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %0t: got %h want %h", $time, g, e); end end
module angx_bank_tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, q;
	logic rdy, err, lerr, npa = 1'b0, ana = 1'b0, snd = 1'b0, flt = 1'b0;
	logic [15:0] wd = 16'h0, base, np, ntx;
	logic pg, pdf, tog, mm, mf, pm, gf, gh;
	logic [2:0] tm;
	int error_cnt = 0, checks = 0, cyc = 0;
	angx_bank dut_u (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
		.PSTRB_I(4'hf), .PREADY_O(rdy), .PSLVERR_O(err), .PRDATA_O(prd),
		.PARTNER_BASE_I(base), .PARTNER_NP_I(np), .PARTNER_NP_ABLE_I(npa),
		.PARTNER_AN_ABLE_I(ana), .PAR_DET_FAULT_I(pdf), .PAGE_RX_I(pg),
		.LAST_CODEWORD_TOGGLE_I(tog), .TEST_MODE_O(tm), .MS_MANUAL_O(mm),
		.MS_FORCE_MASTER_O(mf), .PORT_MULTI_O(pm), .GIG_FDX_ADV_O(gf),
		.GIG_HDX_ADV_O(gh), .NP_TX_WORD_O(ntx));
	angx_partner_model lp_u (.clk_i(clk), .rst_i(rst), .send_i(snd),
		.fault_i(flt), .word_i(wd), .base_o(base), .np_o(np), .page_o(pg),
		.pdf_o(pdf), .tog_o(tog));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Held until the ready edge; data stands with ready, read mid-cycle
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [15:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {16'h0000, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(negedge clk); while (rdy !== 1'b1);
		lerr = err;
		q = prd;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0);
		`CHK(q, {16'h0000, e})
	endtask
	task automatic send(input logic [15:0] w);
		snd <= 1'b1;
		flt <= 1'b1;
		wd <= w;
		@(posedge clk);
		snd <= 1'b0;
		flt <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 5000) begin
				error_cnt++;
				end_sim();
			end
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(`ANGX_OFF_PARTNER, 16'h0000);
		`CHK(lerr, 1'b0)
		rd_chk(`ANGX_OFF_EXPAN, 16'h0004);
		rd_chk(`ANGX_OFF_NPTX, 16'h2801);
		rd_chk(`ANGX_OFF_NPRX, 16'h0000);
		rd_chk(`ANGX_OFF_GIGCTL, 16'h0700);
		`CHK({tm, mm, mf, pm, gf, gh}, 8'h07)
		$display("Test reset values done");
		apb(1'b1, `ANGX_OFF_PARTNER, 16'hffff);
		apb(1'b1, `ANGX_OFF_EXPAN, 16'hffff);
		apb(1'b1, `ANGX_OFF_NPRX, 16'hffff);
		apb(1'b1, 12'h000, 16'hffff);
		`CHK(lerr, 1'b1)
		rd_chk(12'h000, 16'h0000);
		`CHK(lerr, 1'b1)
		rd_chk(`ANGX_OFF_PARTNER, 16'h0000);
		rd_chk(`ANGX_OFF_EXPAN, 16'h0004);
		rd_chk(`ANGX_OFF_NPRX, 16'h0000);
		apb(1'b1, `ANGX_OFF_NPTX, 16'hffff);
		rd_chk(`ANGX_OFF_NPTX, 16'hbfff);
		`CHK(ntx, 16'hbfff)
		apb(1'b1, `ANGX_OFF_NPTX, 16'h0000);
		rd_chk(`ANGX_OFF_NPTX, 16'h0800);
		apb(1'b1, `ANGX_OFF_GIGCTL, 16'h00ff);
		rd_chk(`ANGX_OFF_GIGCTL, 16'h0000);
		`CHK({pm, gf, gh}, 3'b000)
		$display("Test write access done");
		// Media sense sits outside this bank; tests only set the field
		for (int i = 0; i < 5; i++) begin
			wd = {i[2:0], i[0], i[1], 11'h000};
			apb(1'b1, `ANGX_OFF_GIGCTL, wd);
			rd_chk(`ANGX_OFF_GIGCTL, wd);
			`CHK(tm, i[2:0])
			`CHK(mm, i[0])
			`CHK(mf, i[0] & i[1])
		end
		$display("Test gigabit control done");
		npa <= 1'b1;
		ana <= 1'b1;
		send(16'hefe0);
		rd_chk(`ANGX_OFF_EXPAN, 16'h001f);
		rd_chk(`ANGX_OFF_EXPAN, 16'h000d);
		rd_chk(`ANGX_OFF_PARTNER, 16'hefe0);
		rd_chk(`ANGX_OFF_NPRX, 16'h101f);
		rd_chk(`ANGX_OFF_NPTX, 16'h0000);
		send(16'h0000);
		rd_chk(`ANGX_OFF_NPTX, 16'h0800);
		rd_chk(`ANGX_OFF_NPRX, 16'hffff);
		$display("Test partner events done");
		end_sim();
	end
endmodule
`default_nettype wire
